// ===== trace_status_pkg.sv
package trace_status_pkg;

  // Processor state field encodings.
  localparam logic [2:0] STATE_HALT = 3'h0;
  localparam logic [2:0] STATE_PIPE_HOLD = 3'h1;
  localparam logic [2:0] STATE_LOAD_TEST = 3'h2;
  localparam logic [2:0] STATE_WAIT = 3'h3;
  localparam logic [2:0] STATE_IRET = 3'h4;
  localparam logic [2:0] STATE_INTR_TRAP = 3'h5;
  localparam logic [2:0] STATE_NONSEQ = 3'h6;
  localparam logic [2:0] STATE_EXEC = 3'h7;

  // Access option field encodings.
  localparam logic [2:0] OPT_WORD = 3'h0;
  localparam logic [2:0] OPT_BYTE = 3'h1;
  localparam logic [2:0] OPT_HALF = 3'h2;
  localparam logic [2:0] OPT_ROM_DATA = 3'h4;
  localparam logic [2:0] OPT_CACHE = 3'h5;
  localparam logic [2:0] OPT_DEBUG = 3'h6;

  // Data request type encodings; bit 1 set means coprocessor transfer.
  localparam logic [1:0] DREQT_MEM = 2'h0;
  localparam logic [1:0] DREQT_IO = 2'h1;
  localparam int DREQT_COPROC_BIT = 1;

  // Bit positions in the execution-state label vector.
  localparam int EXS_EXEC = 0;
  localparam int EXS_HALT = 1;
  localparam int EXS_LOAD_TEST = 2;
  localparam int EXS_WAIT = 3;
  localparam int EXS_INTR_TRAP = 4;
  localparam int EXS_IRET = 5;
  localparam int EXS_NONSEQ = 6;
  localparam int EXS_PIPE_HOLD = 7;
  localparam int EXS_WIDTH = 8;

  // Bit positions in the access option label vector.
  localparam int OPS_WORD = 0;
  localparam int OPS_BYTE = 1;
  localparam int OPS_HALF = 2;
  localparam int OPS_ROM_DATA = 3;
  localparam int OPS_CACHE = 4;
  localparam int OPS_DEBUG = 5;
  localparam int OPS_RESERVED = 6;
  localparam int OPS_WIDTH = 7;

  // Bit positions in the handshake label vector.
  localparam int HS_CDA = 0;
  localparam int HS_INSTR_BURST_REQ_N = 1;
  localparam int HS_INSTR_BURST_ACK_N = 2;
  localparam int HS_DATA_BURST_REQ_N = 3;
  localparam int HS_DATA_BURST_ACK_N = 4;
  localparam int HS_PIA = 5;
  localparam int HS_PDA = 6;
  localparam int HS_WIDTH = 7;

  // Captured states between the trigger and status capture taking effect.
  localparam int SWITCH_LATENCY = 4;
  // Trace position counter width.
  localparam int POS_WIDTH = 16;

  // Capture modes.
  typedef enum logic [1:0] {
    MODE_INSTR_DATA,
    MODE_DATA_INSTR,
    MODE_STATUS,
    MODE_SWITCHING
  } capture_mode_t;

endpackage

// ===== status_classifier.sv
`timescale 1ns/1ps
module status_classifier
  import trace_status_pkg::*;
(
  input wire logic [2:0] procStateField,
  input wire logic [2:0] accessOptionField,
  input wire logic instrRequestType,
  input wire logic [1:0] dataRequestType,
  input wire logic readNotWrite,
  input wire logic instrBusRequest,
  input wire logic dataBusRequest,
  input wire logic coprocAcceptN,
  input wire logic instrBurstReqN,
  input wire logic instrBurstAckN,
  input wire logic dataBurstReqN,
  input wire logic dataBurstAckN,
  input wire logic pipelinedInstrAccessN,
  input wire logic pipelinedDataAccessN,
  input wire logic [3:0] irqLineN,
  input wire logic [1:0] trapLineN,
  input wire logic statusMode,
  output logic [EXS_WIDTH-1:0] execState,
  output logic [OPS_WIDTH-1:0] accessOpt,
  output logic [2:0] requestKind,
  output logic isRead,
  output logic collision,
  output logic [HS_WIDTH-1:0] handshakes,
  output logic [3:0] irqActive,
  output logic [1:0] trapActive
);

  // Decodes one sampled bus cycle into its label set with no storage.
  always_comb
  begin
    execState = '0;
    case (procStateField)
      STATE_EXEC: execState[EXS_EXEC] = 1'b1;
      STATE_HALT: execState[EXS_HALT] = 1'b1;
      STATE_LOAD_TEST: execState[EXS_LOAD_TEST] = 1'b1;
      STATE_WAIT: execState[EXS_WAIT] = 1'b1;
      STATE_INTR_TRAP: execState[EXS_INTR_TRAP] = 1'b1;
      STATE_IRET: execState[EXS_IRET] = 1'b1;
      STATE_NONSEQ: execState[EXS_NONSEQ] = 1'b1;
      STATE_PIPE_HOLD: execState[EXS_PIPE_HOLD] = 1'b1;
      default: execState = '0;
    endcase
    accessOpt = '0;
    case (accessOptionField)
      OPT_WORD: accessOpt[OPS_WORD] = 1'b1;
      OPT_BYTE: accessOpt[OPS_BYTE] = 1'b1;
      OPT_HALF: accessOpt[OPS_HALF] = 1'b1;
      OPT_ROM_DATA: accessOpt[OPS_ROM_DATA] = 1'b1;
      OPT_CACHE: accessOpt[OPS_CACHE] = 1'b1;
      OPT_DEBUG: accessOpt[OPS_DEBUG] = 1'b1;
      default: accessOpt[OPS_RESERVED] = 1'b1;
    endcase
  end

  // Request kind: bit 0 instruction ROM, bit 1 data I/O, bit 2 coprocessor.
  always_comb
  begin
    requestKind[0] = instrRequestType;
    requestKind[1] = (dataRequestType == DREQT_IO);
    requestKind[2] = dataRequestType[DREQT_COPROC_BIT];
  end

  // Read or write label comes straight from the direction line.
  assign isRead = readNotWrite;

  // Collision is only meaningful outside status capture.
  assign collision = !statusMode && !instrBusRequest && !dataBusRequest;

  // Active-low handshakes reported only in status capture mode.
  always_comb
  begin
    handshakes = '0;
    if (statusMode)
    begin
      handshakes[HS_CDA] = !coprocAcceptN;
      handshakes[HS_INSTR_BURST_REQ_N] = !instrBurstReqN;
      handshakes[HS_INSTR_BURST_ACK_N] = !instrBurstAckN;
      handshakes[HS_DATA_BURST_REQ_N] = !dataBurstReqN;
      handshakes[HS_DATA_BURST_ACK_N] = !dataBurstAckN;
      handshakes[HS_PIA] = !pipelinedInstrAccessN;
      handshakes[HS_PDA] = !pipelinedDataAccessN;
    end
  end

  // Interrupts are always reported, traps only in status capture.
  assign irqActive = ~irqLineN;
  assign trapActive = statusMode ? ~trapLineN : 2'h0;

endmodule

// ===== trace_status_decoder.sv
`timescale 1ns/1ps
module trace_status_decoder
  import trace_status_pkg::*;
#(
  parameter int LATENCY = SWITCH_LATENCY
)
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic [2:0] procStateField,
  input wire logic [2:0] accessOptionField,
  input wire logic instrRequestType,
  input wire logic [1:0] dataRequestType,
  input wire logic readNotWrite,
  input wire logic instrBusRequest,
  input wire logic dataBusRequest,
  input wire logic coprocAcceptN,
  input wire logic instrBurstReqN,
  input wire logic instrBurstAckN,
  input wire logic dataBurstReqN,
  input wire logic dataBurstAckN,
  input wire logic pipelinedInstrAccessN,
  input wire logic pipelinedDataAccessN,
  input wire logic [3:0] irqLineN,
  input wire logic [1:0] trapLineN,
  input wire logic [31:0] busData,
  input wire logic captureStrobe,
  input wire logic traceStart,
  input wire logic triggerMatch,
  input wire logic [1:0] captureModeSel,
  input wire logic crossTriggerEnable,
  input wire logic configWrite,
  output logic crossTriggerLine,
  output logic switchToStatusMode,
  output logic statusModeActive,
  output logic triggered,
  output logic [POS_WIDTH-1:0] tracePosition,
  output logic stateValid,
  output logic isTriggerState,
  output logic monitorBreak,
  output logic [EXS_WIDTH-1:0] execStateLabel,
  output logic [OPS_WIDTH-1:0] accessOptLabel,
  output logic [2:0] requestKindLabel,
  output logic readLabel,
  output logic collisionLabel,
  output logic [HS_WIDTH-1:0] handshakeLabel,
  output logic [3:0] irqLabel,
  output logic [1:0] trapLabel,
  output logic [31:0] dataLabel
);

  // Synchronised copies of every processor pin (two flops each).
  localparam int PW = 3 + 3 + 1 + 2 + 1 + 1 + 1 + 7 + 4 + 2 + 32;
  logic [PW-1:0] pinRaw;
  logic [PW-1:0] pinMeta;
  logic [PW-1:0] pinSync;
  logic [PW-1:0] next_pinMeta;
  logic [PW-1:0] next_pinSync;

  assign pinRaw = {procStateField, accessOptionField, instrRequestType, dataRequestType,
    readNotWrite, instrBusRequest, dataBusRequest, coprocAcceptN, instrBurstReqN,
    instrBurstAckN, dataBurstReqN, dataBurstAckN, pipelinedInstrAccessN,
    pipelinedDataAccessN, irqLineN, trapLineN, busData};

  logic [2:0] sState;
  logic [2:0] sOpt;
  logic sIreqt;
  logic [1:0] sDreqt;
  logic sRw;
  logic sIreq;
  logic sDreq;
  logic sCda;
  logic sIbreq;
  logic sIback;
  logic sDbreq;
  logic sDback;
  logic sPia;
  logic sPda;
  logic [3:0] sIrq;
  logic [1:0] sTrap;
  logic [31:0] sData;

  assign {sState, sOpt, sIreqt, sDreqt, sRw, sIreq, sDreq, sCda, sIbreq, sIback, sDbreq,
    sDback, sPia, sPda, sIrq, sTrap, sData} = pinSync;

  // Synchroniser next values.
  always_comb
  begin
    next_pinMeta = pinRaw;
    next_pinSync = pinMeta;
  end

  // Synchroniser registers.
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      pinMeta <= '0;
      pinSync <= '0;
    end
    else
    begin
      pinMeta <= next_pinMeta;
      pinSync <= next_pinSync;
    end
  end

  // Capture sequencing state.
  typedef enum logic [1:0] {
    SEQ_IDLE,
    SEQ_PRE,
    SEQ_SWITCHING,
    SEQ_POST
  } seq_t;

  seq_t seq;
  seq_t next_seq;
  capture_mode_t mode;
  capture_mode_t next_mode;
  logic statusNow;
  logic next_statusNow;
  logic [POS_WIDTH-1:0] latCount;
  logic [POS_WIDTH-1:0] next_latCount;
  logic [POS_WIDTH-1:0] next_tracePosition;
  logic next_triggered;
  logic next_crossTriggerLine;
  logic next_switchToStatusMode;
  logic next_monitorBreak;
  logic next_isTriggerState;
  logic next_stateValid;
  logic hitNow;

  // Classification uses the current mode, not the one in force when the pins were sampled.
  logic [EXS_WIDTH-1:0] cExec;
  logic [OPS_WIDTH-1:0] cOpt;
  logic [2:0] cReq;
  logic cRead;
  logic cColl;
  logic [HS_WIDTH-1:0] cHs;
  logic [3:0] cIrq;
  logic [1:0] cTrap;

  status_classifier classifier (
    .procStateField(sState),
    .accessOptionField(sOpt),
    .instrRequestType(sIreqt),
    .dataRequestType(sDreqt),
    .readNotWrite(sRw),
    .instrBusRequest(sIreq),
    .dataBusRequest(sDreq),
    .coprocAcceptN(sCda),
    .instrBurstReqN(sIbreq),
    .instrBurstAckN(sIback),
    .dataBurstReqN(sDbreq),
    .dataBurstAckN(sDback),
    .pipelinedInstrAccessN(sPia),
    .pipelinedDataAccessN(sPda),
    .irqLineN(sIrq),
    .trapLineN(sTrap),
    .statusMode(statusNow),
    .execState(cExec),
    .accessOpt(cOpt),
    .requestKind(cReq),
    .isRead(cRead),
    .collision(cColl),
    .handshakes(cHs),
    .irqActive(cIrq),
    .trapActive(cTrap)
  );

  // A trigger counts only on a captured state of a running trace.
  assign hitNow = captureStrobe && triggerMatch && !triggered && (seq != SEQ_IDLE);

  // Sequencer, trace position and cross-trigger next values.
  always_comb
  begin
    next_seq = seq;
    next_mode = mode;
    next_statusNow = statusNow;
    next_latCount = latCount;
    next_tracePosition = tracePosition;
    next_triggered = triggered;
    next_crossTriggerLine = crossTriggerLine;
    next_switchToStatusMode = switchToStatusMode;
    next_monitorBreak = configWrite;
    next_isTriggerState = 1'b0;
    next_stateValid = captureStrobe && (seq != SEQ_IDLE);
    case (seq)
      SEQ_IDLE:
      begin
        if (traceStart && !configWrite)
        begin
          next_seq = SEQ_PRE;
          next_triggered = 1'b0;
          next_crossTriggerLine = 1'b0;
          next_switchToStatusMode = 1'b0;
          next_tracePosition = '0;
          next_statusNow = (mode == MODE_STATUS);
        end
      end
      SEQ_PRE:
      begin
        // Earlier states run at negative positions counting down from zero.
        if (captureStrobe)
        begin
          next_tracePosition = tracePosition - POS_WIDTH'(1);
        end
        if (hitNow)
        begin
          next_triggered = 1'b1;
          next_isTriggerState = 1'b1;
          next_tracePosition = '0;
          next_crossTriggerLine = crossTriggerEnable;
          if (mode == MODE_SWITCHING && crossTriggerEnable)
          begin
            next_switchToStatusMode = 1'b1;
            next_latCount = POS_WIDTH'(LATENCY);
            next_seq = SEQ_SWITCHING;
          end
          else
          begin
            next_seq = SEQ_POST;
          end
        end
      end
      SEQ_SWITCHING:
      begin
        // Status capture starts only after the latency expires.
        if (captureStrobe)
        begin
          next_tracePosition = tracePosition + POS_WIDTH'(1);
          next_latCount = latCount - POS_WIDTH'(1);
          if (latCount <= POS_WIDTH'(1))
          begin
            next_statusNow = 1'b1;
            next_seq = SEQ_POST;
          end
        end
      end
      SEQ_POST:
      begin
        if (captureStrobe)
        begin
          next_tracePosition = tracePosition + POS_WIDTH'(1);
        end
      end
      default: next_seq = SEQ_IDLE;
    endcase
    // A configuration write aborts any trace phase, so it overrides the sequencer last.
    if (configWrite)
    begin
      next_mode = capture_mode_t'(captureModeSel);
      next_seq = SEQ_IDLE;
    end
  end

  // Sequencer registers.
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      seq <= SEQ_IDLE;
      mode <= MODE_INSTR_DATA;
      statusNow <= 1'b0;
      latCount <= '0;
      tracePosition <= '0;
      triggered <= 1'b0;
      crossTriggerLine <= 1'b0;
      switchToStatusMode <= 1'b0;
      monitorBreak <= 1'b0;
      isTriggerState <= 1'b0;
      stateValid <= 1'b0;
    end
    else
    begin
      seq <= next_seq;
      mode <= next_mode;
      statusNow <= next_statusNow;
      latCount <= next_latCount;
      tracePosition <= next_tracePosition;
      triggered <= next_triggered;
      crossTriggerLine <= next_crossTriggerLine;
      switchToStatusMode <= next_switchToStatusMode;
      monitorBreak <= next_monitorBreak;
      isTriggerState <= next_isTriggerState;
      stateValid <= next_stateValid;
    end
  end

  // Registered label set, updated every clock whether or not a state is captured.
  logic [EXS_WIDTH-1:0] next_execStateLabel;
  logic [OPS_WIDTH-1:0] next_accessOptLabel;
  logic [2:0] next_requestKindLabel;
  logic next_readLabel;
  logic next_collisionLabel;
  logic [HS_WIDTH-1:0] next_handshakeLabel;
  logic [3:0] next_irqLabel;
  logic [1:0] next_trapLabel;
  logic [31:0] next_dataLabel;
  logic next_statusModeActive;

  always_comb
  begin
    next_execStateLabel = cExec;
    next_accessOptLabel = cOpt;
    next_requestKindLabel = cReq;
    next_readLabel = cRead;
    next_collisionLabel = cColl;
    next_handshakeLabel = cHs;
    next_irqLabel = cIrq;
    next_trapLabel = cTrap;
    next_dataLabel = statusNow ? sData : '0;
    next_statusModeActive = statusNow;
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      execStateLabel <= '0;
      accessOptLabel <= '0;
      requestKindLabel <= '0;
      readLabel <= 1'b0;
      collisionLabel <= 1'b0;
      handshakeLabel <= '0;
      irqLabel <= '0;
      trapLabel <= '0;
      dataLabel <= '0;
      statusModeActive <= 1'b0;
    end
    else
    begin
      execStateLabel <= next_execStateLabel;
      accessOptLabel <= next_accessOptLabel;
      requestKindLabel <= next_requestKindLabel;
      readLabel <= next_readLabel;
      collisionLabel <= next_collisionLabel;
      handshakeLabel <= next_handshakeLabel;
      irqLabel <= next_irqLabel;
      trapLabel <= next_trapLabel;
      dataLabel <= next_dataLabel;
      statusModeActive <= next_statusModeActive;
    end
  end

endmodule

// ===== target_pin_model.sv
`timescale 1ns/1ps
module target_pin_model
(
  input wire logic [24:0] pattern,
  input wire logic [31:0] dataIn,
  output logic [2:0] procStateField,
  output logic [2:0] accessOptionField,
  output logic instrRequestType,
  output logic [1:0] dataRequestType,
  output logic readNotWrite,
  output logic instrBusRequest,
  output logic dataBusRequest,
  output logic [6:0] handshakeN,
  output logic [3:0] irqLineN,
  output logic [1:0] trapLineN,
  output logic [31:0] busData
);
  // The core's pins follow the commanded pattern; the bench changes it just after an edge.
  assign {trapLineN, irqLineN, handshakeN, dataBusRequest, instrBusRequest, readNotWrite,
    dataRequestType, instrRequestType, accessOptionField, procStateField} = pattern;
  // The data pins are always driven by the core while it runs.
  assign busData = dataIn;
endmodule

// ===== trace_status_decoder_sva.sv
`timescale 1ns/1ps
module trace_status_decoder_sva
  import trace_status_pkg::*;
#(
  parameter int LATENCY = SWITCH_LATENCY
)
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic [2:0] procStateField,
  input wire logic [2:0] accessOptionField,
  input wire logic [1:0] dataRequestType,
  input wire logic [3:0] irqLineN,
  input wire logic captureStrobe,
  input wire logic crossTriggerEnable,
  input wire logic configWrite,
  input wire logic crossTriggerLine,
  input wire logic switchToStatusMode,
  input wire logic statusModeActive,
  input wire logic triggered,
  input wire logic [POS_WIDTH-1:0] tracePosition,
  input wire logic isTriggerState,
  input wire logic monitorBreak,
  input wire logic [EXS_WIDTH-1:0] execStateLabel,
  input wire logic [OPS_WIDTH-1:0] accessOptLabel,
  input wire logic [2:0] requestKindLabel,
  input wire logic collisionLabel,
  input wire logic [HS_WIDTH-1:0] handshakeLabel,
  input wire logic [1:0] trapLabel,
  input wire logic [3:0] irqLabel,
  input wire logic [31:0] dataLabel
);
  logic [2:0] upCnt;
  logic [2:0] next_upCnt;
  logic [7:0] strobeCnt;
  logic [7:0] next_strobeCnt;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  // Cycles since reset, so the three-stage pin pipeline is full, and strobes since trigger.
  always_comb
  begin
    next_upCnt = (upCnt == 3'h4) ? upCnt : upCnt + 3'h1;
    next_strobeCnt = strobeCnt;
    if (isTriggerState)
      next_strobeCnt = 8'h00;
    else if (captureStrobe && strobeCnt != 8'hFF)
      next_strobeCnt = strobeCnt + 8'h01;
  end
  // Registers the helper counters.
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      upCnt <= 3'h0;
      strobeCnt <= 8'h00;
    end
    else
    begin
      upCnt <= next_upCnt;
      strobeCnt <= next_strobeCnt;
    end
  end
  property p_mon; configWrite |=> monitorBreak; endproperty
  a_mon: assert property (p_mon) else $error("no monitor break after config write");
  property p_irq; upCnt == 3'h4 |-> irqLabel == ~$past(irqLineN, 3); endproperty
  a_irq: assert property (p_irq) else $error("interrupt label wrong");
  property p_exec;
    upCnt == 3'h4 |-> $onehot(execStateLabel)
      && execStateLabel[EXS_EXEC] == ($past(procStateField, 3) == STATE_EXEC);
  endproperty
  a_exec: assert property (p_exec) else $error("execute label wrong");
  property p_intr;
    upCnt == 3'h4 |-> execStateLabel[EXS_INTR_TRAP] == ($past(procStateField, 3) == STATE_INTR_TRAP)
      && execStateLabel[EXS_PIPE_HOLD] == ($past(procStateField, 3) == STATE_PIPE_HOLD);
  endproperty
  a_intr: assert property (p_intr) else $error("trap or hold label wrong");
  property p_opt;
    upCnt == 3'h4 |-> accessOptLabel[OPS_RESERVED] == ($past(accessOptionField[1:0], 3) == 2'h3);
  endproperty
  a_opt: assert property (p_opt) else $error("reserved option label wrong");
  property p_req;
    upCnt == 3'h4 |-> requestKindLabel[2] == $past(dataRequestType[1], 3)
      && requestKindLabel[1] == ($past(dataRequestType, 3) == DREQT_IO);
  endproperty
  a_req: assert property (p_req) else $error("request kind label wrong");
  property p_coll; statusModeActive |-> !collisionLabel; endproperty
  a_coll: assert property (p_coll) else $error("collision shown in status mode");
  property p_quiet;
    !statusModeActive |-> handshakeLabel == '0 && trapLabel == 2'h0 && dataLabel == '0;
  endproperty
  a_quiet: assert property (p_quiet) else $error("status labels outside status mode");
  property p_trig; isTriggerState |-> tracePosition == '0 && triggered ##1 !isTriggerState;
  endproperty
  a_trig: assert property (p_trig) else $error("trigger state not at position zero");
  property p_xtrig; $rose(triggered) && crossTriggerEnable |-> crossTriggerLine; endproperty
  a_xtrig: assert property (p_xtrig) else $error("cross trigger line not driven");
  property p_sw; switchToStatusMode |-> crossTriggerLine && triggered; endproperty
  a_sw: assert property (p_sw) else $error("mode switch without trigger line");
  property p_lat;
    $rose(statusModeActive) && switchToStatusMode |-> strobeCnt >= LATENCY - 1;
  endproperty
  a_lat: assert property (p_lat) else $error("status capture started too early");
endmodule
bind trace_status_decoder trace_status_decoder_sva #(.LATENCY(LATENCY)) chk (.clk, .nrst,
  .procStateField, .accessOptionField, .dataRequestType, .irqLineN, .captureStrobe,
  .crossTriggerEnable, .configWrite, .crossTriggerLine, .switchToStatusMode, .statusModeActive,
  .triggered, .tracePosition, .isTriggerState, .monitorBreak, .execStateLabel, .accessOptLabel,
  .requestKindLabel, .collisionLabel, .handshakeLabel, .trapLabel, .irqLabel, .dataLabel);

// ===== trace_status_decoder_bench.sv
`timescale 1ns/1ps
module trace_status_decoder_bench
  import trace_status_pkg::*;
;
  localparam int LAT = 2;
  localparam int execMap[8] = '{EXS_HALT, EXS_PIPE_HOLD, EXS_LOAD_TEST, EXS_WAIT, EXS_IRET,
    EXS_INTR_TRAP, EXS_NONSEQ, EXS_EXEC};
  localparam int optMap[8] = '{OPS_WORD, OPS_BYTE, OPS_HALF, OPS_RESERVED, OPS_ROM_DATA,
    OPS_CACHE, OPS_DEBUG, OPS_RESERVED};
  logic clk, nrst, captureStrobe, traceStart, triggerMatch, crossTriggerEnable, configWrite;
  logic [1:0] captureModeSel;
  logic [24:0] pattern;
  logic [31:0] dataIn, busData;
  logic [2:0] procStateField, accessOptionField, requestKindLabel;
  logic instrRequestType, readNotWrite, instrBusRequest, dataBusRequest;
  logic [1:0] dataRequestType, trapLineN, trapLabel;
  logic [6:0] handshakeN;
  logic [3:0] irqLineN, irqLabel;
  logic crossTriggerLine, switchToStatusMode, statusModeActive, triggered, stateValid;
  logic isTriggerState, monitorBreak, readLabel, collisionLabel;
  logic [POS_WIDTH-1:0] tracePosition;
  logic [EXS_WIDTH-1:0] execStateLabel;
  logic [OPS_WIDTH-1:0] accessOptLabel;
  logic [HS_WIDTH-1:0] handshakeLabel;
  logic [31:0] dataLabel;
  int err_count = 0;
  int tests_run = 0;
  target_pin_model core (.pattern, .dataIn, .procStateField, .accessOptionField,
    .instrRequestType, .dataRequestType, .readNotWrite, .instrBusRequest, .dataBusRequest,
    .handshakeN, .irqLineN, .trapLineN, .busData);
  trace_status_decoder #(.LATENCY(LAT)) uut (.clk, .nrst, .procStateField, .accessOptionField,
    .instrRequestType, .dataRequestType, .readNotWrite, .instrBusRequest, .dataBusRequest,
    .coprocAcceptN(handshakeN[0]), .instrBurstReqN(handshakeN[1]),
    .instrBurstAckN(handshakeN[2]), .dataBurstReqN(handshakeN[3]),
    .dataBurstAckN(handshakeN[4]), .pipelinedInstrAccessN(handshakeN[5]),
    .pipelinedDataAccessN(handshakeN[6]), .irqLineN, .trapLineN, .busData, .captureStrobe,
    .traceStart, .triggerMatch, .captureModeSel, .crossTriggerEnable, .configWrite,
    .crossTriggerLine, .switchToStatusMode, .statusModeActive, .triggered, .tracePosition,
    .stateValid, .isTriggerState, .monitorBreak, .execStateLabel, .accessOptLabel,
    .requestKindLabel, .readLabel, .collisionLabel, .handshakeLabel, .irqLabel, .trapLabel,
    .dataLabel);
  // Clock at 200 MHz.
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // Counts one comparison and reports a mismatch at once.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      err_count++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Prints the counts and the verdict, then stops.
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // Drives new pin levels and waits until the labels have passed the pin pipeline.
  task automatic pins(input logic [24:0] p, input logic [31:0] d);
    @(posedge clk);
    pattern <= p;
    dataIn <= d;
    repeat (5) @(posedge clk);
    #1;
  endtask
  // Writes the configuration, checks the monitor break, then starts a trace.
  task automatic cfg(input logic [1:0] mode, input logic en);
    @(posedge clk);
    configWrite <= 1'b1;
    captureModeSel <= mode;
    crossTriggerEnable <= en;
    @(posedge clk);
    configWrite <= 1'b0;
    #1 chk(monitorBreak, 1'b1);
    @(posedge clk);
    traceStart <= 1'b1;
    @(posedge clk);
    traceStart <= 1'b0;
  endtask
  // Captures a few states, fires the trigger, then offers a second trigger that is ignored.
  task automatic trig(input logic en);
    @(posedge clk);
    captureStrobe <= 1'b1;
    repeat (3) @(posedge clk);
    triggerMatch <= 1'b1;
    @(posedge clk);
    triggerMatch <= 1'b0;
    #1 chk(isTriggerState, 1'b1);
    chk(tracePosition, 32'h0);
    chk({triggered, stateValid}, 2'h3);
    chk(crossTriggerLine, en);
    chk(switchToStatusMode, en);
    chk(statusModeActive, 1'b0);
    @(posedge clk);
    triggerMatch <= 1'b1;
    @(posedge clk);
    triggerMatch <= 1'b0;
    #1 chk(isTriggerState, 1'b0);
    repeat (LAT + 5) @(posedge clk);
    captureStrobe <= 1'b0;
    #1 chk(statusModeActive, en);
  endtask
  // Watchdog against a hang.
  initial
  begin
    repeat (20000) @(posedge clk);
    err_count++;
    end_of_test();
  end
  // Main sequence.
  initial
  begin
    logic [2:0] i;
    nrst = 1'b0;
    {captureStrobe, traceStart, triggerMatch, crossTriggerEnable, configWrite} = 5'h00;
    captureModeSel = 2'h0;
    pattern = 25'h1FFFFFF;
    dataIn = 32'h00000000;
    repeat (2) @(posedge clk);
    #1 chk({irqLabel, execStateLabel, monitorBreak, triggered}, 32'h0);
    @(posedge clk);
    nrst <= 1'b1;
    cfg(2'h0, 1'b0);
    for (int k = 0; k < 8; k++)
    begin
      i = k[2:0];
      pins({2'h3, 4'hF ^ (4'h1 << i[1:0]), 7'h7F, i[1], i[0], i[2], i[1:0], i[0], i, i},
        32'h12345678);
      chk(execStateLabel, 32'h1 << execMap[k]);
      chk(accessOptLabel, 32'h1 << optMap[k]);
      chk(requestKindLabel, {i[1], i[1:0] == 2'h1, i[0]});
      chk(readLabel, i[2]);
      chk(collisionLabel, i[1:0] == 2'h0);
      chk(irqLabel, 4'h1 << i[1:0]);
      chk({handshakeLabel, trapLabel}, 32'h0);
      chk(dataLabel, 32'h0);
      chk(stateValid, 1'b0);
    end
    $display("test classify done");
    cfg(2'h2, 1'b0);
    for (int k = 0; k < 7; k++)
    begin
      pins({2'h3 ^ (2'h1 << k[0]), 4'hF, 7'h7F ^ (7'h01 << k), 2'h0, 1'b1, 2'h0, 1'b0, 6'h3F},
        32'hA5000000 | k);
      chk(handshakeLabel, 32'h1 << k);
      chk(trapLabel, 2'h1 << k[0]);
      chk(dataLabel, 32'hA5000000 | k);
      chk(collisionLabel, 1'b0);
    end
    $display("test status done");
    pins({2'h3, 4'hF, 7'h00, 2'h0, 1'b1, 2'h0, 1'b0, 6'h3F}, 32'h0000C0DE);
    cfg(2'h3, 1'b1);
    repeat (4) @(posedge clk);
    #1 chk(collisionLabel, 1'b1);
    trig(1'b1);
    chk(handshakeLabel, 32'h7F);
    chk(dataLabel, 32'h0000C0DE);
    $display("test switch done");
    cfg(2'h3, 1'b0);
    trig(1'b0);
    $display("test no switch done");
    end_of_test();
  end
endmodule
